// >>> core/tmr_core.sv
`timescale 1ns/1ps
// Function
// - force bit applies output action, non-PWM only
// - forced compare sets no flag, no clear
// - force bits always read zero
// - reserved bits read zero
// - codes 0-5 stop or prescaled clock
// - codes 6,7 count external falling/rising edge
// - external pin counts regardless of direction
// - counter directly readable and writable
// - counter write blocks next compare
// - compare registers continuously matched, drive pins
// - irq needs mask, global enable, flag
// - match sets compare flags
// - vector execution clears flag
// - write one clears flag
// - overflow flag per waveform mode
// - wave mode selects count sequence, top
// - non-PWM output modes off/toggle/clear/set
module tmr_core (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              ext_count_pin,
	input  wire logic              global_irq_en,
	output tmr_pkg::tmr_wave_t     wave,
	output logic                   irq_ovf,
	output logic                   irq_cmp_a,
	output logic                   irq_cmp_b
);
	import tmr_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	tmr_ctrl_a_t ctrl_a_r;        // output modes, low wave bits
	logic        wave_mode_hi_r;  // wave mode bit 2
	logic [2:0]  clk_source_sel_r;
	logic [7:0]  counter_value_r;
	logic [7:0]  cmp_value_a_r;   // active compare A
	logic [7:0]  cmp_value_b_r;
	logic [7:0]  cmp_buf_a_r;     // software-written buffer A
	logic [7:0]  cmp_buf_b_r;
	logic [2:0]  irq_mask_r;
	logic [2:0]  flags_r;
	logic        count_down_r;    // phase-correct direction
	logic        block_cmp_r;     // counter write pending
	logic        out_a_r;
	logic        out_b_r;
	logic [9:0]  presc_r;
	logic        pin_s1_r;        // sync stage 1
	logic        pin_s2_r;        // sync stage 2
	logic        pin_s3_r;        // edge history

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire wr_en    = psel & penable & pwrite;
	wire wr_ctl_a = wr_en & (paddr == ADDR_CTRL_A);
	wire wr_ctl_b = wr_en & (paddr == ADDR_CTRL_B);
	wire wr_cnt   = wr_en & (paddr == ADDR_COUNT);
	wire wr_cmp_a = wr_en & (paddr == ADDR_CMP_A);
	wire wr_cmp_b = wr_en & (paddr == ADDR_CMP_B);
	wire wr_mask  = wr_en & (paddr == ADDR_MASK);
	wire wr_flags = wr_en & (paddr == ADDR_FLAGS);
	wire wr_ack   = wr_en & (paddr == ADDR_ACK);
	wire mapped   = (paddr <= ADDR_ACK) & (paddr[1:0] == 2'h0);
	assign pready  = 1'b1;
	// unmapped access answers with an error, reads zero
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	wire [2:0] wave_mode = {wave_mode_hi_r, ctrl_a_r.wave_mode_lo};
	wire is_pc   = (wave_mode == WM_PC_FF) | (wave_mode == WM_PC_A);
	wire is_fp   = (wave_mode == WM_FP_FF) | (wave_mode == WM_FP_A);
	wire is_pwm  = is_pc | is_fp;
	wire top_a   = (wave_mode == WM_CTC) | (wave_mode == WM_PC_A)
	             | (wave_mode == WM_FP_A);
	wire [7:0] top_val = top_a ? cmp_value_a_r : VAL_MAX;
	wire at_top  = (counter_value_r == top_val);

	// ----------------------------------------
	// clock select and prescaler
	// ----------------------------------------
	// one-cycle pulse at each wrap of the mask
	wire p8    = ((presc_r & DIV_8_MASK)  == DIV_8_MASK);
	wire p64   = ((presc_r & DIV_64_MASK) == DIV_64_MASK);
	wire p256  = ((presc_r & DIV_256_MSK) == DIV_256_MSK);
	wire p1k   = ((presc_r & DIV_1K_MASK) == DIV_1K_MASK);
	wire fall  = pin_s3_r & ~pin_s2_r;
	wire rise  = ~pin_s3_r & pin_s2_r;
	logic tick;
	always_comb begin
		unique case (clk_source_sel_r)
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = p8;
			CS_D64:  tick = p64;
			CS_D256: tick = p256;
			CS_D1K:  tick = p1k;
			CS_FALL: tick = fall;
			CS_RISE: tick = rise;
		endcase
	end

	// prescaler free-runs; no reset on select change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r <= 10'h000;
		end else begin
			presc_r <= presc_r + 10'h001;
		end
	end

	// pin sampled whatever its direction
	// two-stage sync then history stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= ext_count_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// ----------------------------------------
	// compare and counting
	// ----------------------------------------
	// continuous compare, gated by tick
	// suppressed on tick after counter write
	wire match_a = tick & ~block_cmp_r & (counter_value_r == cmp_value_a_r);
	wire match_b = tick & ~block_cmp_r & (counter_value_r == cmp_value_b_r);
	// in CTC only real matches clear the counter
	wire ctc_clr = (wave_mode == WM_CTC) & match_a;
	wire ovf_ev  = tick & (is_pc ? (count_down_r & counter_value_r == 8'h01)
	             : (wave_mode == WM_FP_A) ? at_top
	             : (counter_value_r == VAL_MAX) & ~ctc_clr);
	logic [7:0] count_nxt;
	always_comb begin
		count_nxt = counter_value_r;
		if (tick) begin
			if (is_pc) begin
				count_nxt = count_down_r ? counter_value_r - 8'h01
				                         : counter_value_r + 8'h01;
			end else if (ctc_clr | (is_fp & at_top)) begin
				count_nxt = VAL_BOTTOM;
			end else begin
				count_nxt = counter_value_r + 8'h01;
			end
		end
	end
	// phase-correct turns at top and bottom
	wire down_nxt = ~is_pc ? 1'b0
	              : (count_nxt == top_val) ? 1'b1
	              : (count_nxt == VAL_BOTTOM) ? 1'b0 : count_down_r;
	// PWM modes load compares at top, others at once
	wire upd_cmp  = ~is_pwm | (tick & at_top);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_r <= RST_BYTE;
			count_down_r    <= 1'b0;
			block_cmp_r     <= 1'b0;
		end else begin
			counter_value_r <= wr_cnt ? pwdata[7:0] : count_nxt;
			count_down_r    <= down_nxt;
			block_cmp_r     <= wr_cnt | (block_cmp_r & ~tick);
		end
	end

	// compare buffers and active values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_buf_a_r   <= RST_BYTE;
			cmp_buf_b_r   <= RST_BYTE;
			cmp_value_a_r <= RST_BYTE;
			cmp_value_b_r <= RST_BYTE;
		end else begin
			if (wr_cmp_a) cmp_buf_a_r <= pwdata[7:0];
			if (wr_cmp_b) cmp_buf_b_r <= pwdata[7:0];
			if (upd_cmp) begin
				cmp_value_a_r <= wr_cmp_a ? pwdata[7:0] : cmp_buf_a_r;
				cmp_value_b_r <= wr_cmp_b ? pwdata[7:0] : cmp_buf_b_r;
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_r         <= '0;
			wave_mode_hi_r   <= 1'b0;
			clk_source_sel_r <= CS_STOP;
			irq_mask_r       <= 3'h0;
		end else begin
			if (wr_ctl_a) ctrl_a_r <= tmr_ctrl_a_t'({pwdata[7:4], 2'h0, pwdata[1:0]});
			if (wr_ctl_b) begin
				wave_mode_hi_r   <= pwdata[BIT_WAVE_HI];
				clk_source_sel_r <= pwdata[2:0];
			end
			if (wr_mask) irq_mask_r <= pwdata[2:0];
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	// match sets compare flags
	wire [2:0] flag_set = {match_b, match_a, ovf_ev};
	// write one clears; vector ack clears
	wire [2:0] flag_clr = (wr_flags ? pwdata[2:0] : 3'h0)
	                    | (wr_ack   ? pwdata[2:0] : 3'h0);
	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= 3'h0;
		end else begin
			flags_r <= flag_set | (flags_r & ~flag_clr);
		end
	end

	assign irq_ovf   = global_irq_en & irq_mask_r[BIT_OVF]   & flags_r[BIT_OVF];
	assign irq_cmp_a = global_irq_en & irq_mask_r[BIT_CMP_A] & flags_r[BIT_CMP_A];
	assign irq_cmp_b = global_irq_en & irq_mask_r[BIT_CMP_B] & flags_r[BIT_CMP_B];

	// ----------------------------------------
	// waveform outputs
	// ----------------------------------------
	// force strobe only outside PWM modes
	wire force_a = wr_ctl_b & pwdata[BIT_FORCE_A] & ~is_pwm;
	wire force_b = wr_ctl_b & pwdata[BIT_FORCE_B] & ~is_pwm;
	// next pin level for one channel
	function automatic logic pin_nxt(input logic cur, input logic [1:0] om,
	                                 input logic hit, input logic pwm,
	                                 input logic dn, input logic attop);
		logic r;
		r = cur;
		if (!pwm) begin
			// toggle, clear or set on match
			if (hit) begin
				unique case (om)
					OM_OFF: r = cur;
					OM_TGL: r = ~cur;
					OM_CLR: r = 1'b0;
					OM_SET: r = 1'b1;
				endcase
			end
		end else if (om[1]) begin
			if (hit) r = om[0] ^ dn;
			else if (attop & ~dn) r = ~om[0];
		end
		return r;
	endfunction
	wire pc_dn = is_pc & count_down_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_a_r <= 1'b0;
			out_b_r <= 1'b0;
		end else begin
			out_a_r <= pin_nxt(out_a_r, ctrl_a_r.out_mode_a, match_a | force_a,
			                   is_pwm, pc_dn, tick & at_top & is_fp);
			out_b_r <= pin_nxt(out_b_r, ctrl_a_r.out_mode_b, match_b | force_b,
			                   is_pwm, pc_dn, tick & at_top & is_fp);
		end
	end
	assign wave.wave_out_a = out_a_r;
	assign wave.wave_en_a  = (ctrl_a_r.out_mode_a != OM_OFF);
	assign wave.wave_out_b = out_b_r;
	assign wave.wave_en_b  = (ctrl_a_r.out_mode_b != OM_OFF);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// force bits read zero; reserved zero
	wire [7:0] rd_ctl_b = {4'h0, wave_mode_hi_r, clk_source_sel_r};
	wire [7:0] rd_byte  = (paddr == ADDR_CTRL_A) ? ctrl_a_r
	                    : (paddr == ADDR_CTRL_B) ? rd_ctl_b
	                    : (paddr == ADDR_COUNT)  ? counter_value_r
	                    : (paddr == ADDR_CMP_A)  ? cmp_buf_a_r
	                    : (paddr == ADDR_CMP_B)  ? cmp_buf_b_r
	                    : (paddr == ADDR_MASK)   ? {5'h00, irq_mask_r}
	                    : (paddr == ADDR_FLAGS)  ? {5'h00, flags_r} : 8'h00;
	assign prdata = {24'h000000, rd_byte};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// strobe sets no flag
	a_force_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(force_a & ~match_a) |=> ~$rose(flags_r[BIT_CMP_A]))
		else $error("forced compare set flag A");
	a_ctlb_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(paddr == ADDR_CTRL_B) |-> (prdata[7:4] == 4'h0))
		else $error("control B upper bits not zero");
	a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_source_sel_r == CS_STOP & ~wr_cnt) |=> $stable(counter_value_r))
		else $error("counter moved while stopped");
	a_cnt_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_cnt |=> (counter_value_r == $past(pwdata[7:0])))
		else $error("counter write lost");
	a_write_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_cnt ##1 tick) |-> ~match_a & ~match_b)
		else $error("match after counter write");
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		irq_cmp_a |-> global_irq_en & irq_mask_r[BIT_CMP_A] & flags_r[BIT_CMP_A])
		else $error("irq A without cause");
	a_match_sets: assert property (@(posedge pclk) disable iff (!presetn)
		match_b |=> flags_r[BIT_CMP_B])
		else $error("flag B not set on match");
	a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_flags & pwdata[BIT_OVF] & ~ovf_ev) |=> ~flags_r[BIT_OVF])
		else $error("overflow flag not cleared");
	a_div1_counts: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_source_sel_r == CS_DIV1 & wave_mode == WM_NORMAL & ~wr_cnt)
		|=> counter_value_r == $past(counter_value_r) + 8'h01)
		else $error("undivided clock did not count");
	a_rise_one: assert property (@(posedge pclk) disable iff (!presetn)
		rise |=> ~rise)
		else $error("double edge detect");
	// mode checks below only look one tick ahead; a wrong top value
	// that still wraps somewhere is left to the bench's counter reads
	// clear-on-compare wraps to bottom
	a_ctc_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(wave_mode == WM_CTC & match_a & ~wr_cnt) |=> counter_value_r == VAL_BOTTOM)
		else $error("clear-on-compare did not wrap");
	a_ctc_no_ovf: assert property (@(posedge pclk) disable iff (!presetn)
		(wave_mode == WM_CTC & tick & counter_value_r != VAL_MAX)
		|=> ~$rose(flags_r[BIT_OVF]))
		else $error("overflow flag below max");
	a_pc_bottom: assert property (@(posedge pclk) disable iff (!presetn)
		(is_pc & ovf_ev & ~wr_cnt) |=> counter_value_r == VAL_BOTTOM)
		else $error("phase-correct overflow off bottom");
	a_force_pwm: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctl_b & is_pwm & ~tick) |=> $stable(out_a_r) & $stable(out_b_r))
		else $error("force strobe acted in pwm mode");
	a_presc_once: assert property (@(posedge pclk) disable iff (!presetn)
		p8 |=> ~p8)
		else $error("prescaler pulse too long");
	a_flags_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
		(paddr == ADDR_FLAGS) |-> prdata[31:3] == 29'h0)
		else $error("flag reserved bits not zero");
endmodule

// >>> core/tmr_pkg.sv
package tmr_pkg;
	// ----------------------------------------
	// register map (byte addresses, own choice)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_CMP_A  = 8'h0c;
	localparam logic [7:0] ADDR_CMP_B  = 8'h10;
	localparam logic [7:0] ADDR_MASK   = 8'h14;
	localparam logic [7:0] ADDR_FLAGS  = 8'h18;
	localparam logic [7:0] ADDR_ACK    = 8'h1c;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned BIT_FORCE_A = 7;
	localparam int unsigned BIT_FORCE_B = 6;
	localparam int unsigned BIT_WAVE_HI = 3;
	localparam int unsigned BIT_OVF     = 0;
	localparam int unsigned BIT_CMP_A   = 1;
	localparam int unsigned BIT_CMP_B   = 2;
	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam logic [7:0]  VAL_MAX     = 8'hff;
	localparam logic [7:0]  VAL_BOTTOM  = 8'h00;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [9:0]  DIV_8_MASK  = 10'h007;
	localparam logic [9:0]  DIV_64_MASK = 10'h03f;
	localparam logic [9:0]  DIV_256_MSK = 10'h0ff;
	localparam logic [9:0]  DIV_1K_MASK = 10'h3ff;
	// clock-source codes
	localparam logic [2:0]  CS_STOP = 3'h0;
	localparam logic [2:0]  CS_DIV1 = 3'h1;
	localparam logic [2:0]  CS_DIV8 = 3'h2;
	localparam logic [2:0]  CS_D64  = 3'h3;
	localparam logic [2:0]  CS_D256 = 3'h4;
	localparam logic [2:0]  CS_D1K  = 3'h5;
	localparam logic [2:0]  CS_FALL = 3'h6;
	localparam logic [2:0]  CS_RISE = 3'h7;
	// waveform modes
	localparam logic [2:0]  WM_NORMAL = 3'h0;
	localparam logic [2:0]  WM_PC_FF  = 3'h1;
	localparam logic [2:0]  WM_CTC    = 3'h2;
	localparam logic [2:0]  WM_FP_FF  = 3'h3;
	localparam logic [2:0]  WM_PC_A   = 3'h5;
	localparam logic [2:0]  WM_FP_A   = 3'h7;
	// output-mode codes
	localparam logic [1:0]  OM_OFF = 2'h0;
	localparam logic [1:0]  OM_TGL = 2'h1;
	localparam logic [1:0]  OM_CLR = 2'h2;
	localparam logic [1:0]  OM_SET = 2'h3;

	// control A carrier: output modes and low wave bits
	typedef struct packed {
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [1:0] rsvd;
		logic [1:0] wave_mode_lo;
	} tmr_ctrl_a_t;

	// pin outputs travel together
	typedef struct packed {
		logic wave_out_a;
		logic wave_en_a;
		logic wave_out_b;
		logic wave_en_b;
	} tmr_wave_t;
endpackage

// >>> test/tmr_tb.sv
`timescale 1ns/1ps
module tb;
	import tmr_pkg::*;
	// ----------------------------------------
	// bench signals
	// ----------------------------------------
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, perr;
	logic        ext_count_pin, global_irq_en;
	logic        irq_ovf, irq_cmp_a, irq_cmp_b;
	tmr_wave_t   wave;
	int          bad_count, total_checks, cycles;
	// prescaler ratios for codes 1 to 5
	int          dv[5] = '{1, 8, 64, 256, 1024};

	tmr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
		.global_irq_en(global_irq_en), .wave(wave), .irq_ovf(irq_ovf),
		.irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b));

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ceiling well above the longest prescaler run
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; entered just after an edge, holds until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic irqs(input logic [31:0] exp);
		chk({29'h0, irq_ovf, irq_cmp_a, irq_cmp_b}, exp);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			ext_count_pin <= 1'b1;
			cyc(6);
			ext_count_pin <= 1'b0;
			cyc(6);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// reset values, strobe and reserved bits, unmapped slot
	task automatic t_regs();
		logic [7:0] al[7] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_COUNT, ADDR_CMP_A,
			ADDR_CMP_B, ADDR_MASK, ADDR_FLAGS};
		foreach (al[i]) rd(al[i], 32'h0);
		wr(ADDR_CTRL_B, 32'hff);
		rd(ADDR_CTRL_B, 32'h0f);
		wr(ADDR_CTRL_B, 32'h00);
		wr(ADDR_MASK, 32'hff);
		rd(ADDR_MASK, 32'h07);
		wr(ADDR_MASK, 32'h00);
		rd(8'h20, 32'h0);
		chk({31'h0, perr}, 32'h1);
	endtask
	// forced compare: action per output mode, ignored in pwm, no side effects
	task automatic t_force();
		wr(ADDR_CTRL_A, 32'h70);
		wr(ADDR_CTRL_B, 32'hc0);
		chk(32'(wave), 32'h0f);
		rd(ADDR_FLAGS, 32'h0);
		wr(ADDR_CTRL_A, 32'ha3);
		wr(ADDR_CTRL_B, 32'hc0);
		chk(32'(wave), 32'h0f);
		wr(ADDR_CTRL_B, 32'h00);
		chk(32'(wave), 32'h0f);
		wr(ADDR_CTRL_A, 32'ha0);
		wr(ADDR_CTRL_B, 32'hc0);
		chk(32'(wave), 32'h05);
		wr(ADDR_COUNT, 32'h05);
		wr(ADDR_CTRL_A, 32'h02);
		wr(ADDR_CTRL_B, 32'h80);
		rd(ADDR_COUNT, 32'h05);
		rd(ADDR_FLAGS, 32'h0);
	endtask
	// every prescaled ratio; phase is free-running so allow a small window
	task automatic t_prescale();
		int hi;
		wr(ADDR_CTRL_A, 32'h00);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_COUNT, 32'h0);
			wr(ADDR_CTRL_B, 32'(i + 1));
			cyc(8 * dv[i]);
			wr(ADDR_CTRL_B, 32'h0);
			hi = (8 * dv[i] + 3) / dv[i] + 1;
			apb(1'b0, ADDR_COUNT, 32'h0);
			chk(32'((rdat >= 8 && rdat <= hi) ? 1 : 0), 32'h1);
		end
		wr(ADDR_COUNT, 32'h33);
		cyc(50);
		rd(ADDR_COUNT, 32'h33);
	endtask
	// matches, overflow, pin toggle, gating, both ways of clearing
	task automatic t_match();
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_A, 32'h40);
		wr(ADDR_CMP_A, 32'hfe);
		wr(ADDR_CMP_B, 32'hff);
		wr(ADDR_COUNT, 32'hfd);
		wr(ADDR_CTRL_B, 32'h01);
		cyc(10);
		wr(ADDR_CTRL_B, 32'h00);
		rd(ADDR_FLAGS, 32'h07);
		chk({31'h0, wave.wave_out_a}, 32'h1);
		irqs(32'h0);
		wr(ADDR_MASK, 32'h07);
		irqs(32'h0);
		global_irq_en <= 1'b1;
		cyc(1);
		irqs(32'h07);
		wr(ADDR_MASK, 32'h05);
		irqs(32'h05);
		wr(ADDR_FLAGS, 32'h02);
		rd(ADDR_FLAGS, 32'h05);
		wr(ADDR_FLAGS, 32'h00);
		rd(ADDR_FLAGS, 32'h05);
		wr(ADDR_ACK, 32'h01);
		rd(ADDR_FLAGS, 32'h04);
		irqs(32'h01);
		wr(ADDR_ACK, 32'h04);
		rd(ADDR_FLAGS, 32'h00);
		global_irq_en <= 1'b0;
	endtask
	// counter written onto the compare value: that match is dropped
	task automatic t_block();
		wr(ADDR_CMP_A, 32'h10);
		wr(ADDR_CMP_B, 32'h12);
		wr(ADDR_COUNT, 32'h10);
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_B, 32'h01);
		cyc(4);
		wr(ADDR_CTRL_B, 32'h00);
		rd(ADDR_FLAGS, 32'h04);
		// same again with the counter written while it runs
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_B, 32'h01);
		wr(ADDR_COUNT, 32'h10);
		cyc(2);
		wr(ADDR_CTRL_B, 32'h00);
		rd(ADDR_FLAGS, 32'h04);
	endtask
	// external pin, rising then falling edges, one count per edge
	task automatic t_ext();
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL_B, 32'h07);
		pulse(3);
		rd(ADDR_COUNT, 32'h03);
		wr(ADDR_CTRL_B, 32'h06);
		pulse(3);
		rd(ADDR_COUNT, 32'h06);
		wr(ADDR_CTRL_B, 32'h00);
	endtask
	// top at compare a = 4, eleven ticks per run: ctc, fast pwm, phase correct
	task automatic t_modes();
		wr(ADDR_CMP_A, 32'h04);
		wr(ADDR_CTRL_A, 32'h02);
		wr(ADDR_COUNT, 32'h00);
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_B, 32'h01);
		cyc(8);
		wr(ADDR_CTRL_B, 32'h00);
		rd(ADDR_COUNT, 32'h01);
		rd(ADDR_FLAGS, 32'h02);
		wr(ADDR_CTRL_A, 32'h03);
		wr(ADDR_COUNT, 32'h00);
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_B, 32'h09);
		cyc(8);
		wr(ADDR_CTRL_B, 32'h08);
		rd(ADDR_COUNT, 32'h01);
		rd(ADDR_FLAGS, 32'h03);
		wr(ADDR_CTRL_A, 32'h01);
		wr(ADDR_COUNT, 32'h00);
		wr(ADDR_FLAGS, 32'h07);
		wr(ADDR_CTRL_B, 32'h09);
		cyc(8);
		wr(ADDR_CTRL_B, 32'h08);
		rd(ADDR_COUNT, 32'h03);
		rd(ADDR_FLAGS, 32'h03);
		wr(ADDR_CTRL_A, 32'h00);
		wr(ADDR_CTRL_B, 32'h00);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, ext_count_pin, global_irq_en} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_force();
		t_prescale();
		t_match();
		t_block();
		t_ext();
		t_modes();
		tally_and_finish();
	end
endmodule
